//--- verilog/pfpc_top.sv
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module pfpc_top (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [pfpc_pkg::PIN_COUNT-1:0] pin_in,
	output logic [pfpc_pkg::PIN_COUNT-1:0] pin_out,
	output logic [pfpc_pkg::PIN_COUNT-1:0] pin_oe,
	output logic [pfpc_pkg::PIN_COUNT-1:0] analog_select,
	input wire logic [pfpc_pkg::PIN_COUNT-1:0] func_two_out,
	input wire logic [pfpc_pkg::PIN_COUNT-1:0] func_two_oe,
	output logic [pfpc_pkg::PIN_COUNT-1:0] func_two_in,
	input wire logic [pfpc_pkg::PIN_COUNT-1:0] func_three_out,
	input wire logic [pfpc_pkg::PIN_COUNT-1:0] func_three_oe,
	output logic [pfpc_pkg::PIN_COUNT-1:0] func_three_in,
	input wire logic [pfpc_pkg::PIN_COUNT-1:0] func_four_out,
	input wire logic [pfpc_pkg::PIN_COUNT-1:0] func_four_oe,
	output logic [pfpc_pkg::PIN_COUNT-1:0] func_four_in
);
	import pfpc_pkg::*;

	// ==========================================================
	// bus slave state
	logic wr_pend_q;
	logic [DECODE_W-1:0] wr_addr_q;
	logic [DATA_W-1:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic addr_valid;
	logic [DECODE_W-1:0] rd_mux;

	// ==========================================================
	// configuration registers
	logic [7:0] out_en_q, out_en_d;
	logic [7:0] fsel1_q, fsel1_d;
	logic [7:0] fsel2_q, fsel2_d;
	logic [7:0] fsel3_q, fsel3_d;
	logic [7:0] fsel4_q, fsel4_d;
	logic [7:0] drive_q, drive_d;
	logic [7:0] level_q, level_d;
	logic [7:0] in_en_q, in_en_d;

	// ==========================================================
	// pin outputs
	logic [PIN_COUNT-1:0] pin_out_q, pin_out_d;
	logic [PIN_COUNT-1:0] pin_oe_q, pin_oe_d;
	logic [PIN_COUNT-1:0] analog_q, analog_d;
	logic [PIN_COUNT-1:0] f2_in_q, f2_in_d;
	logic [PIN_COUNT-1:0] f3_in_q, f3_in_d;
	logic [PIN_COUNT-1:0] f4_in_q, f4_in_d;
	logic [PIN_COUNT-1:0] port_mode;
	logic [PIN_COUNT-1:0] pin_seen;
	logic [PIN_COUNT-1:0] port_push;
	pfpc_src_t src_sel [PIN_COUNT];

	assign addr_valid = hsel && hready && (htrans[1] != HTRANS_IDLE[1]);

	// ==========================================================
	// address phase capture
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			wr_pend_q <= addr_valid && hwrite;
			wr_addr_q <= haddr[DECODE_W-1:0];
			hreadyout_q <= 1'b1;
			hresp_q <= HRESP_OKAY[0];
		end
	end

	// ==========================================================
	// register write, masked to the writable bits
	always_comb begin
		out_en_d = out_en_q;
		fsel1_d = fsel1_q;
		fsel2_d = fsel2_q;
		fsel3_d = fsel3_q;
		fsel4_d = fsel4_q;
		drive_d = drive_q;
		level_d = level_q;
		in_en_d = in_en_q;
		if (wr_pend_q) begin
			case (wr_addr_q)
				OFS_OUTPUT_ENABLE: out_en_d = hwdata[7:0] & MASK_FULL;
				OFS_FUNC_SEL_ONE: fsel1_d = hwdata[7:0] & MASK_FULL;
				OFS_FUNC_SEL_TWO: fsel2_d = hwdata[7:0] & MASK_FUNC_SEL_TWO;
				OFS_FUNC_SEL_THREE: fsel3_d = hwdata[7:0] & MASK_FULL;
				OFS_FUNC_SEL_FOUR: fsel4_d = hwdata[7:0] & MASK_FUNC_SEL_FOUR;
				OFS_DRIVE_TYPE: drive_d = hwdata[7:0] & MASK_FULL;
				OFS_PIN_LEVEL: level_d = hwdata[7:0] & MASK_FULL;
				OFS_INPUT_ENABLE: in_en_d = hwdata[7:0] & MASK_FULL;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			out_en_q <= RESET_REG;
			fsel1_q <= RESET_REG;
			fsel2_q <= RESET_REG;
			fsel3_q <= RESET_REG;
			fsel4_q <= RESET_REG;
			drive_q <= RESET_REG;
			level_q <= RESET_REG;
			in_en_q <= RESET_REG;
		end else begin
			out_en_q <= out_en_d;
			fsel1_q <= fsel1_d;
			fsel2_q <= fsel2_d;
			fsel3_q <= fsel3_d;
			fsel4_q <= fsel4_d;
			drive_q <= drive_d;
			level_q <= level_d;
			in_en_q <= in_en_d;
		end
	end

	// ==========================================================
	// read mux; uses next values so a read right after a write sees it
	always_comb begin
		case (haddr[DECODE_W-1:0])
			OFS_PIN_LEVEL: rd_mux = (level_d & port_mode & out_en_d) | pin_seen;
			OFS_OUTPUT_ENABLE: rd_mux = out_en_d;
			OFS_FUNC_SEL_ONE: rd_mux = fsel1_d;
			OFS_FUNC_SEL_TWO: rd_mux = fsel2_d;
			OFS_FUNC_SEL_THREE: rd_mux = fsel3_d;
			OFS_FUNC_SEL_FOUR: rd_mux = fsel4_d;
			OFS_DRIVE_TYPE: rd_mux = drive_d;
			OFS_INPUT_ENABLE: rd_mux = in_en_d;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hrdata_q <= 32'h00000000;
		end else if (addr_valid && !hwrite) begin
			hrdata_q <= {READ_ZERO_HIGH, rd_mux};
		end
	end

	// ==========================================================
	// per-pin source selection and driver
	for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
		logic drv_level;
		logic drv_en;

		assign src_sel[n] = fsel1_q[n] ? SRC_ANALOG :
			fsel2_q[n] ? SRC_FUNC_TWO :
			fsel3_q[n] ? SRC_FUNC_THREE :
			fsel4_q[n] ? SRC_FUNC_FOUR : SRC_PORT;

		always_comb begin
			case (src_sel[n])
				SRC_PORT: begin
					drv_level = level_q[n];
					drv_en = out_en_q[n];
				end
				SRC_FUNC_TWO: begin
					drv_level = func_two_out[n];
					drv_en = out_en_q[n] && func_two_oe[n];
				end
				SRC_FUNC_THREE: begin
					drv_level = func_three_out[n];
					drv_en = out_en_q[n] && func_three_oe[n];
				end
				SRC_FUNC_FOUR: begin
					drv_level = func_four_out[n];
					drv_en = out_en_q[n] && func_four_oe[n];
				end
				default: begin
					drv_level = 1'b0;
					drv_en = 1'b0;
				end
			endcase
		end

		// open-drain drives low only, releases for high
		assign pin_out_d[n] = drive_q[n] ? 1'b0 : drv_level;
		assign pin_oe_d[n] = drv_en && (!drive_q[n] || !drv_level);
		assign analog_d[n] = (src_sel[n] == SRC_ANALOG);
		assign port_mode[n] = (src_sel[n] == SRC_PORT);
		assign pin_seen[n] = pin_in[n] && in_en_q[n] && !(out_en_q[n] && port_mode[n]);
		assign f2_in_d[n] = pin_in[n] && in_en_q[n] && (src_sel[n] == SRC_FUNC_TWO);
		assign f3_in_d[n] = pin_in[n] && in_en_q[n] && (src_sel[n] == SRC_FUNC_THREE);
		assign f4_in_d[n] = pin_in[n] && in_en_q[n] && (src_sel[n] == SRC_FUNC_FOUR);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_out_q <= 8'h00;
			pin_oe_q <= 8'h00;
			analog_q <= 8'h00;
			f2_in_q <= 8'h00;
			f3_in_q <= 8'h00;
			f4_in_q <= 8'h00;
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			analog_q <= analog_d;
			f2_in_q <= f2_in_d;
			f3_in_q <= f3_in_d;
			f4_in_q <= f4_in_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign analog_select = analog_q;
	assign func_two_in = f2_in_q;
	assign func_three_in = f3_in_q;
	assign func_four_in = f4_in_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_write(logic [7:0] ofs);
		(hsel && hready && htrans[1] && hwrite && haddr[7:0] == ofs) ##1 1'b1;
	endsequence

	property p_write_lands(logic [7:0] ofs, logic [7:0] q, logic [7:0] mask);
		s_write(ofs) |=> (q == ($past(hwdata[7:0]) & mask));
	endproperty

	chk_output_enable_write: assert property (p_write_lands(OFS_OUTPUT_ENABLE, out_en_q, MASK_FULL))
		else $error("output enable write lost");
	chk_func_one_write: assert property (p_write_lands(OFS_FUNC_SEL_ONE, fsel1_q, MASK_FULL))
		else $error("function one write lost");
	chk_func_two_mask: assert property (p_write_lands(OFS_FUNC_SEL_TWO, fsel2_q, MASK_FUNC_SEL_TWO))
		else $error("function two bits wrong");
	chk_func_three_write: assert property (p_write_lands(OFS_FUNC_SEL_THREE, fsel3_q, MASK_FULL))
		else $error("function three write lost");
	chk_func_four_mask: assert property (p_write_lands(OFS_FUNC_SEL_FOUR, fsel4_q, MASK_FUNC_SEL_FOUR))
		else $error("function four bits wrong");
	chk_drive_type_write: assert property (p_write_lands(OFS_DRIVE_TYPE, drive_q, MASK_FULL))
		else $error("drive type write lost");
	chk_pin_level_write: assert property (p_write_lands(OFS_PIN_LEVEL, level_q, MASK_FULL))
		else $error("pin level write lost");
	chk_input_enable_write: assert property (p_write_lands(OFS_INPUT_ENABLE, in_en_q, MASK_FULL))
		else $error("input enable write lost");
	chk_read_high_zero: assert property (hrdata_q[31:8] == 24'h000000)
		else $error("high read bits not zero");
	chk_no_drive_disabled: assert property (out_en_q == 8'h00 |=> pin_oe_q == 8'h00)
		else $error("pin driven while disabled");
	chk_open_drain_low: assert property ((drive_q & ~pin_oe_d) == drive_q |=>
		(pin_oe_q & $past(drive_q)) == 8'h00)
		else $error("open-drain pin driven");
	chk_od_never_high: assert property ($past(drive_q) != 8'h00 |->
		(pin_oe_q & pin_out_q & $past(drive_q)) == 8'h00)
		else $error("open-drain pin driven high");
	chk_analog_wins: assert property ((fsel1_q & (fsel2_q | fsel3_q | fsel4_q)) != 8'h00 |=>
		(analog_q & $past(fsel1_q)) == $past(fsel1_q) && (pin_oe_q & $past(fsel1_q)) == 8'h00)
		else $error("analog select lost priority");
	chk_input_gated: assert property (in_en_q == 8'h00 |=>
		(f2_in_q | f3_in_q | f4_in_q) == 8'h00)
		else $error("input passed while disabled");
	chk_bus_always_ready: assert property (hreadyout_q && hresp_q == HRESP_OKAY[0])
		else $error("bus not ready or not okay");
	chk_func_two_fixed: assert property (fsel2_q[3:0] == 4'h0)
		else $error("function two fixed bits set");
	chk_func_four_fixed: assert property ((fsel4_q & ~MASK_FUNC_SEL_FOUR) == 8'h00)
		else $error("function four fixed bits set");
	chk_analog_undriven: assert property ((analog_q & pin_oe_q) == 8'h00)
		else $error("analog pin driven");

	// push-pull port pins show the level register one edge later
	assign port_push = out_en_q & ~drive_q & port_mode;
	chk_port_level_out: assert property (port_push != 8'h00 |=>
		(pin_out_q & $past(port_push)) == ($past(level_q) & $past(port_push)))
		else $error("port pin level wrong");
	chk_reset_clears: assert property (disable iff (1'b0) !reset_n |=>
		pin_oe_q == 8'h00 && analog_q == 8'h00 && out_en_q == 8'h00)
		else $error("reset left pins active");

endmodule

`default_nettype wire

//--- pkg/pfpc_pkg.sv
package pfpc_pkg;

	// ==========================================================
	// port geometry
	localparam int unsigned PIN_COUNT = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned DECODE_W = 8;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h00;
	localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h04;
	localparam logic [7:0] OFS_FUNC_SEL_ONE = 8'h08;
	localparam logic [7:0] OFS_FUNC_SEL_TWO = 8'h0c;
	localparam logic [7:0] OFS_FUNC_SEL_THREE = 8'h10;
	localparam logic [7:0] OFS_FUNC_SEL_FOUR = 8'h14;
	localparam logic [7:0] OFS_DRIVE_TYPE = 8'h28;
	localparam logic [7:0] OFS_INPUT_ENABLE = 8'h38;

	// ==========================================================
	// writable bits and reset values
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_FUNC_SEL_TWO = 8'hf0;
	localparam logic [7:0] MASK_FUNC_SEL_FOUR = 8'he6;
	localparam logic [7:0] RESET_REG = 8'h00;
	localparam logic [23:0] READ_ZERO_HIGH = 24'h000000;

	// ==========================================================
	// peripheral signal bit positions
	localparam int unsigned BIT_ENCODER_PHASE_A = 7;
	localparam int unsigned BIT_ENCODER_PHASE_B = 6;
	localparam int unsigned BIT_ENCODER_INDEX = 5;
	localparam int unsigned BIT_EXTERNAL_INTERRUPT_ZERO = 4;
	localparam int unsigned BIT_UART_TERMINAL_READY = 7;
	localparam int unsigned BIT_UART_SET_READY = 6;
	localparam int unsigned BIT_UART_RING_INDICATE = 5;
	localparam int unsigned BIT_UART_CARRIER_DETECT = 4;
	localparam int unsigned BIT_UART_REQUEST_TO_SEND = 3;
	localparam int unsigned BIT_UART_RECEIVE_LINE = 2;
	localparam int unsigned BIT_UART_TRANSMIT_LINE = 1;
	localparam int unsigned BIT_UART_CLEAR_TO_SEND = 0;
	localparam int unsigned BIT_SERIAL_OUT_OR_I2C_DATA = 7;
	localparam int unsigned BIT_SERIAL_IN_OR_I2C_CLOCK = 6;
	localparam int unsigned BIT_SYNCHRONOUS_SERIAL_CLOCK = 5;
	localparam int unsigned BIT_INFRARED_RECEIVE = 2;
	localparam int unsigned BIT_INFRARED_TRANSMIT = 1;

	// ==========================================================
	// bus encodings
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// ==========================================================
	// per-pin signal source, one-hot
	typedef enum logic [4:0] {
		SRC_PORT = 5'h01,
		SRC_ANALOG = 5'h02,
		SRC_FUNC_TWO = 5'h04,
		SRC_FUNC_THREE = 5'h08,
		SRC_FUNC_FOUR = 5'h10
	} pfpc_src_t;

endpackage

//--- verification/pfpc_pins_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========
// pin wires and peripheral signal sources
module pfpc_pins_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_level,
	input wire logic [7:0] peri_val,
	output logic [7:0] pin_in,
	output logic [7:0] two_out,
	output logic [7:0] three_out,
	output logic [7:0] four_out
);
	// released pins show the outside driver, never the last device value
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
	// distinct pattern per function so a wrong route shows
	assign two_out = peri_val;
	assign three_out = ~peri_val;
	assign four_out = peri_val ^ 8'h5a;
endmodule

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
	import pfpc_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = HTRANS_IDLE;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp;
	logic [7:0] pin_in, pin_out, pin_oe, analog_select;
	logic [7:0] ext_level = 8'h00;
	logic [7:0] peri_val = 8'h00;
	logic [7:0] peri_oe = 8'h00;
	logic [7:0] f2o, f3o, f4o, f2i, f3i, f4i;
	int err_total = 0;
	int checks = 0;
	logic [7:0] offs [7] = '{OFS_OUTPUT_ENABLE, OFS_FUNC_SEL_ONE, OFS_FUNC_SEL_TWO,
		OFS_FUNC_SEL_THREE, OFS_FUNC_SEL_FOUR, OFS_DRIVE_TYPE, OFS_INPUT_ENABLE};
	logic [7:0] msk [7] = '{8'hff, 8'hff, 8'hf0, 8'hff, 8'he6, 8'hff, 8'hff};
	logic [7:0] vexp [3] = '{8'h96, 8'h69, 8'hcc};

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	pfpc_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .analog_select(analog_select),
		.func_two_out(f2o), .func_two_oe(peri_oe), .func_two_in(f2i),
		.func_three_out(f3o), .func_three_oe(peri_oe), .func_three_in(f3i),
		.func_four_out(f4o), .func_four_oe(peri_oe), .func_four_in(f4i));
	pfpc_pins_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
		.peri_val(peri_val), .pin_in(pin_in), .two_out(f2o), .three_out(f3o),
		.four_out(f4o));

	// ==========
	// reporting and bus access
	task automatic tally_and_finish();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic await_ready();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			err_total++;
			tally_and_finish();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		await_ready();
		htrans <= HTRANS_IDLE;
		hwdata <= wd;
		await_ready();
		rd = hrdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(hresp, HRESP_OKAY);
	endtask

	task automatic settle();
		repeat (3) @(posedge ref_clk);
	endtask

	// ==========
	// scenarios
	task automatic reset_values();
		for (int i = 0; i < 7; i++) begin
			rdc(offs[i], 32'h0);
		end
		rdc(OFS_PIN_LEVEL, 32'h0);
		chk({pin_oe, analog_select}, 16'h0);
	endtask

	task automatic reg_access();
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, offs[i], 32'hffffffff);
			rdc(offs[i], {24'h0, msk[i]});
			bus(1'b1, offs[i], 32'h0);
		end
		bus(1'b1, 8'h18, 32'hffffffff);
		rdc(8'h18, 32'h0);
	endtask

	task automatic port_drive();
		bus(1'b1, OFS_OUTPUT_ENABLE, 32'hff);
		bus(1'b1, OFS_PIN_LEVEL, 32'ha5);
		settle();
		chk(pin_oe, 8'hff);
		chk(pin_out, 8'ha5);
		rdc(OFS_PIN_LEVEL, 32'ha5);
		bus(1'b1, OFS_DRIVE_TYPE, 32'h0f);
		settle();
		chk({pin_oe, pin_out}, 16'hfaa0);
		bus(1'b1, OFS_OUTPUT_ENABLE, 32'h0);
		bus(1'b1, OFS_DRIVE_TYPE, 32'h0);
		ext_level <= 8'h3c;
		bus(1'b1, OFS_INPUT_ENABLE, 32'h0f);
		settle();
		chk(pin_oe, 8'h00);
		rdc(OFS_PIN_LEVEL, 32'h0c);
	endtask

	task automatic functions();
		logic [7:0] m;
		bus(1'b1, OFS_OUTPUT_ENABLE, 32'hff);
		bus(1'b1, OFS_INPUT_ENABLE, 32'hff);
		ext_level <= 8'hc3;
		peri_val <= 8'h96;
		peri_oe <= 8'h3c;
		for (int k = 0; k < 3; k++) begin
			m = msk[k + 2];
			bus(1'b1, offs[k + 2], {24'h0, m});
			settle();
			chk(pin_oe & m, 8'h3c & m);
			chk(pin_out & m & 8'h3c, vexp[k] & m & 8'h3c);
			chk((k == 0 ? f2i : k == 1 ? f3i : f4i) & m, ((vexp[k] & 8'h3c) | 8'hc3) & m);
			bus(1'b1, offs[k + 2], 32'h0);
		end
		peri_oe <= 8'hff;
		bus(1'b1, OFS_FUNC_SEL_ONE, 32'h01);
		bus(1'b1, OFS_FUNC_SEL_TWO, 32'hf0);
		bus(1'b1, OFS_FUNC_SEL_THREE, 32'hff);
		settle();
		chk(analog_select, 8'h01);
		chk({pin_oe, pin_out & 8'hfe}, 16'hfe98);
		bus(1'b1, OFS_FUNC_SEL_ONE, 32'h81);
		settle();
		chk({analog_select, pin_oe}, 16'h817e);
	endtask

	// ==========
	// main sequence, with a second reset in mid-run
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		reset_values();
		reg_access();
		port_drive();
		functions();
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		reset_values();
		tally_and_finish();
	end
endmodule

`default_nettype wire
